// file: cacl_core.sv
// Commutation advance timer, acceleration current limit and fault stop with AXI4-Lite registers
//
// Behaviour
// R1 - Drive fires advance time before estimated zero cross
// R2 - Mode zero: advance equals programmed setting
// R3 - Mode one: setting scaled by (U-BEMF)/U
// R4 - Setting is 2.5 us times mantissa shifted
// R5 - Codes span zero to 4800 us
// R6 - Cap amplitude at limit*resistance plus speed*constant
// R7 - Limit uses programmed values, no current sense
// R8 - Limit keeps motor running, raises no fault
// R9 - Limit applies only in closed loop
// R10 - Lock trip stops drive, flags rotation error
// R11 - Overcurrent stops drive, resumes, flags connection
// R12 - Overcurrent stop always active, fixed threshold
// R13 - Resistance and constant are seven-bit settings
// R14 - Unit tick from clock, reload on zero cross
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module cacl_core (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [3:0]           s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  input  wire logic                 zero_cross,
  input  wire logic                 closed_loop,
  input  wire cacl_pkg::cacl_motor_s motor,
  input  wire logic                 lock_trip_pin,
  input  wire logic                 overcurrent_signal,
  output logic                      commutate,
  output logic [8:0]                drive_amplitude,
  output logic                      drive_enable,
  output logic                      accel_limit_active,
  output logic                      lock_state,
  output logic                      irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  cacl_pkg::cacl_cfg_s cfg;
  logic [1:0]          status;
  logic [1:0]          mask;
  logic                oc_active;
  logic [1:0]          lock_sync;
  logic [1:0]          oc_sync;
  logic [8:0]          tick_cnt;
  logic                tick;
  logic [15:0]         period_cnt;
  logic [15:0]         period;
  logic [15:0]         adv_cnt;
  logic                adv_armed;
  logic [10:0]         adv_used;

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  wire        aw_take   = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  wire        wr_en     = s_axi_awready & s_axi_awvalid;
  wire        ar_take   = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  wire        rd_en     = s_axi_arready & s_axi_arvalid;
  wire        wr_ctrl   = wr_en & (s_axi_awaddr == cacl_pkg::OFS_CTRL);
  wire        wr_mask   = wr_en & (s_axi_awaddr == cacl_pkg::OFS_MASK);
  wire        wr_state  = wr_en & (s_axi_awaddr == cacl_pkg::OFS_STATE);
  wire        wr_hit    = wr_ctrl | wr_mask | wr_state | (s_axi_awaddr == cacl_pkg::OFS_STATUS);
  wire        rd_status = rd_en & (s_axi_araddr == cacl_pkg::OFS_STATUS);
  wire        rd_hit    = (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] lane_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] ctrl_new  = ((cfg & ~lane_mask) | (s_axi_wdata & lane_mask))
                          & cacl_pkg::CTRL_WMASK;
  wire        lock_release = wr_state & s_axi_wstrb[0] & s_axi_wdata[0];

  // Read data selection, unused bits read as zero
  wire [31:0] state_word = {26'h000_0000, motor.phase_amplitude == 9'h000, closed_loop,
                            drive_enable, accel_limit_active, oc_active, lock_state};
  wire [31:0] rd_mux = (s_axi_araddr == cacl_pkg::OFS_CTRL)   ? 32'(cfg) :
                       (s_axi_araddr == cacl_pkg::OFS_STATUS) ? {30'h0000_0000, status} :
                       (s_axi_araddr == cacl_pkg::OFS_MASK)   ? {30'h0000_0000, mask} :
                                                                state_word;

  // Write channel: both address and data taken together, one response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cacl_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= aw_take;
      s_axi_wready  <= aw_take;
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? cacl_pkg::RESP_OKAY : cacl_pkg::RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cacl_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ar_take;
      if (rd_en) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? rd_mux : 32'h0000_0000;
        s_axi_rresp  <= rd_hit ? cacl_pkg::RESP_OKAY : cacl_pkg::RESP_SLV;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Configuration and mask registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg  <= cacl_pkg::CTRL_RESET;
      mask <= 2'h0;
    end else begin
      if (wr_ctrl)
        cfg <= ctrl_new;  // R13
      if (wr_mask && s_axi_wstrb[0])
        mask <= s_axi_wdata[1:0];
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_sync <= 2'b00;
      oc_sync   <= 2'b00;
    end else begin
      lock_sync <= {lock_sync[0], lock_trip_pin};
      oc_sync   <= {oc_sync[0], overcurrent_signal};
    end
  end

  wire lock_s = lock_sync[1];
  wire oc_s   = oc_sync[1];

  // ****************************************************************
  // Advance time
  // ****************************************************************
  // Setting in 2.5 us units: mantissa shifted by exponent
  wire [10:0] setting_ticks = 11'({7'h00, cfg.advance_time_code[3:0]}
                                   << cfg.advance_time_code[6:4]);  // R4 R5
  wire        u_valid    = (motor.phase_amplitude > motor.bemf_amplitude);
  wire [8:0]  u_minus_b  = motor.phase_amplitude - motor.bemf_amplitude;
  wire [19:0] scaled_num = 20'(setting_ticks) * 20'(u_minus_b);
  wire [10:0] scaled     = u_valid ? 11'(scaled_num / 20'(motor.phase_amplitude)) : 11'h000;
  wire [10:0] adv_target = cfg.advance_mode_select ? scaled : setting_ticks;  // R2 R3
  wire [15:0] adv_load   = (period > 16'(adv_target)) ? period - 16'(adv_target) : 16'h0000;

  // Unit tick prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 9'h000;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 9'(cacl_pkg::TICK_CYCLES - 2));  // R14
      tick_cnt <= (tick_cnt == 9'(cacl_pkg::TICK_CYCLES - 1)) ? 9'h000 : tick_cnt + 9'h001;
    end
  end

  // Period measurement and advance countdown, reloaded on each zero cross
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_cnt <= 16'h0000;
      period     <= 16'h0000;
      adv_cnt    <= 16'h0000;
      adv_armed  <= 1'b0;
      adv_used   <= 11'h000;
      commutate  <= 1'b0;
    end else begin
      commutate <= adv_armed && (adv_cnt == 16'h0000) && drive_enable;  // R1
      if (zero_cross) begin
        period     <= period_cnt;
        period_cnt <= 16'h0000;
        adv_cnt    <= adv_load;  // R14
        adv_used   <= adv_target;
        adv_armed  <= 1'b1;
      end else begin
        if (tick && period_cnt != 16'hFFFF)
          period_cnt <= period_cnt + 16'h0001;
        if (adv_armed && adv_cnt == 16'h0000)
          adv_armed <= 1'b0;
        else if (tick && adv_cnt != 16'h0000)
          adv_cnt <= adv_cnt - 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Acceleration current limit
  // ****************************************************************
  // Voltage cap from programmed threshold, resistance and constant with speed, no current sense
  wire [17:0] limit_ir   = 18'(cfg.accel_current_threshold) * 18'(cfg.winding_resistance_setting);
  wire [17:0] limit_kv   = 18'(motor.speed) * 18'(cfg.velocity_constant_setting);
  wire [17:0] u_limit    = limit_ir + limit_kv;  // R6 R7
  wire        over_limit = closed_loop && (18'(motor.phase_amplitude) > u_limit);  // R9

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_amplitude    <= 9'h000;
      accel_limit_active <= 1'b0;
    end else begin
      drive_amplitude    <= over_limit ? u_limit[8:0] : motor.phase_amplitude;  // R6
      accel_limit_active <= over_limit;  // R8
    end
  end

  // ****************************************************************
  // Fault stop
  // ****************************************************************
  wire next_lock = lock_s | (lock_state & ~lock_release);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_state   <= 1'b0;
      oc_active    <= 1'b0;
      drive_enable <= 1'b0;
    end else begin
      lock_state   <= next_lock;  // R10
      oc_active    <= oc_s;  // R12
      drive_enable <= ~(next_lock | oc_s);  // R10 R11
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  wire [1:0] events = {oc_s & ~oc_active, lock_s & ~lock_state};

  // Sticky status, a new event wins over the clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 2'h0;
      irq    <= 1'b0;
    end else begin
      status <= (rd_status ? 2'h0 : status) | events;  // R10 R11
      irq    <= |(status & mask);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_lock_rise;
    !lock_state ##1 lock_s;
  endsequence

  sequence s_stopped;
    lock_state && !drive_enable;
  endsequence

  property p_tick_spacing;
    @(posedge aclk) disable iff (!aresetn)
    tick |=> (!tick)[*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)  // R14
    else $error("Unit tick repeats too soon");

  property p_zc_reload;
    @(posedge aclk) disable iff (!aresetn)
    zero_cross |=> adv_armed && adv_cnt == $past(adv_load);
  endproperty
  a_zc_reload: assert property (p_zc_reload)  // R14
    else $error("Advance counter not reloaded on zero cross");

  property p_mode_fixed;
    @(posedge aclk) disable iff (!aresetn)
    zero_cross && !cfg.advance_mode_select |=> adv_used == $past(setting_ticks);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)  // R2
    else $error("Fixed advance differs from setting");

  property p_mode_scaled;
    @(posedge aclk) disable iff (!aresetn)
    zero_cross && cfg.advance_mode_select
      |=> adv_used <= $past(setting_ticks)
          && (($past(motor.bemf_amplitude) != 9'h000) || adv_used == $past(setting_ticks));
  endproperty
  a_mode_scaled: assert property (p_mode_scaled)  // R3
    else $error("Scaled advance out of range");

  property p_max_code;
    @(posedge aclk) disable iff (!aresetn)
    cfg.advance_time_code == 7'h7F |-> setting_ticks == 11'(cacl_pkg::ADV_MAX_TICKS);
  endproperty
  a_max_code: assert property (p_max_code)  // R5
    else $error("All-ones code does not give longest advance");

  property p_limit_cap;
    @(posedge aclk) disable iff (!aresetn)
    over_limit |=> accel_limit_active && drive_amplitude == $past(u_limit[8:0]);
  endproperty
  a_limit_cap: assert property (p_limit_cap)  // R6
    else $error("Amplitude not capped");

  property p_open_loop;
    @(posedge aclk) disable iff (!aresetn)
    !closed_loop |=> !accel_limit_active && drive_amplitude == $past(motor.phase_amplitude);
  endproperty
  a_open_loop: assert property (p_open_loop)  // R9
    else $error("Limit applied in open loop");

  property p_lock_stop;
    @(posedge aclk) disable iff (!aresetn)
    s_lock_rise |=> s_stopped ##1 status[cacl_pkg::ST_LOCK];
  endproperty
  a_lock_stop: assert property (p_lock_stop)  // R10
    else $error("Lock trip did not stop drive");

  property p_oc_resume;
    @(posedge aclk) disable iff (!aresetn)
    !oc_s && !next_lock |=> drive_enable;
  endproperty
  a_oc_resume: assert property (p_oc_resume)  // R11
    else $error("Drive did not resume after overcurrent");

  property p_oc_stop;
    @(posedge aclk) disable iff (!aresetn)
    oc_s |=> !drive_enable && oc_active;
  endproperty
  a_oc_stop: assert property (p_oc_stop)  // R12
    else $error("Overcurrent did not stop drive");

  property p_limit_no_fault;
    @(posedge aclk) disable iff (!aresetn)
    accel_limit_active && !lock_state && !oc_active |-> drive_enable;
  endproperty
  a_limit_no_fault: assert property (p_limit_no_fault)  // R8
    else $error("Acceleration limit stopped the drive");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    |(status & mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt missing for unmasked event");

endmodule : cacl_core

// file: cacl_motor_model.sv
// Motor model that returns estimated zero cross pulses at a set spacing
`timescale 1ns/1ps
module cacl_motor_model (
  input  wire logic aclk,
  input  wire logic spin,
  input  wire logic [31:0] gap,
  output logic      zero_cross
);
  int cnt = 0;

  // ****************************************************************
  // Pulse train, one cycle wide, gap cycles apart while spinning
  // ****************************************************************
  initial zero_cross = 1'b0;
  always @(posedge aclk) begin
    if (!spin) begin
      cnt        <= 0;
      zero_cross <= 1'b0;
    end else if (cnt == 0) begin
      cnt        <= gap - 1;
      zero_cross <= 1'b1;
    end else begin
      cnt        <= cnt - 1;
      zero_cross <= 1'b0;
    end
  end
endmodule : cacl_motor_model

// file: cacl_pkg.sv
// Constants, register map and carrier types for the advance and current-limit block
package cacl_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;                         // 200 MHz clock
  localparam int ADV_UNIT_PS   = 2500000;                      // 2.5 us advance unit
  localparam int TICK_CYCLES   = ADV_UNIT_PS / CLK_PERIOD_PS;  // Cycles per unit
  localparam int ADV_MAX_US    = 4800;                         // Longest advance
  // Worked in ns so the product stays inside a 32-bit int
  localparam int ADV_MAX_TICKS = (ADV_MAX_US * 1000) / (ADV_UNIT_PS / 1000);

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] OFS_CTRL   = 4'h0;   // Configuration
  localparam logic [3:0] OFS_STATUS = 4'h4;   // Sticky events, read clears
  localparam logic [3:0] OFS_MASK   = 4'h8;   // Interrupt mask
  localparam logic [3:0] OFS_STATE  = 4'hC;   // Live state, write bit 0 releases lock

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h03FF_FFFF;
  localparam logic [1:0]  STAT_W     = 2'h2;
  localparam int          ST_LOCK    = 0;     // Lock trip seen
  localparam int          ST_CONN    = 1;     // Overcurrent seen
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLV   = 2'b10;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [5:0] rsvd;
    logic [6:0] velocity_constant_setting;
    logic [6:0] winding_resistance_setting;
    logic [3:0] accel_current_threshold;
    logic       advance_mode_select;
    logic [6:0] advance_time_code;
  } cacl_cfg_s;

  typedef struct packed {
    logic [8:0] phase_amplitude;     // U, commanded amplitude
    logic [8:0] bemf_amplitude;      // Estimated BEMF amplitude
    logic [9:0] speed;               // Electrical speed
  } cacl_motor_s;

endpackage : cacl_pkg

// file: tb_top.sv
// Self-checking bench for the advance and current-limit block
`timescale 1ns/1ps
module tb_top;
  // ****************************************************************
  // Signals and bookkeeping
  // ****************************************************************
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, zero_cross, closed_loop, lock_pin;
  logic        oc_pin, commutate, drive_enable, accel_act, lock_state, irq, spin;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, seed;
  logic [1:0]  bresp, rresp;
  logic [8:0]  drive_amp, u;
  logic        cl;
  cacl_pkg::cacl_motor_s motor;
  int          gap, errors, compares, arm, zc_seen, since, cycles;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          cq[$];

  cacl_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .zero_cross(zero_cross), .closed_loop(closed_loop),
    .motor(motor), .lock_trip_pin(lock_pin), .overcurrent_signal(oc_pin),
    .commutate(commutate), .drive_amplitude(drive_amp), .drive_enable(drive_enable),
    .accel_limit_active(accel_act), .lock_state(lock_state), .irq(irq));

  cacl_motor_model i_motor (.aclk(aclk), .spin(spin), .gap(gap), .zero_cross(zero_cross));

  // ****************************************************************
  // Helpers: random source, compares, bus cycles, verdict
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
  endfunction : lfsr

  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_time(input int exp, input int got);
    compares++;
    if (got < exp - 600 || got > exp + 600) begin
      errors++;
      $display("mismatch advance cycles expected %0d seen %0d", exp, got);
    end
  endtask : chk_time

  // Response ready stays high between transfers; only the bench timeout ends a wait
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
  endtask : axi_rd

  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // Advance run: three zero crosses, then the last one's drive point is timed
  task automatic adv_run(input logic [7:0] code, input int exp_ticks);
    int n;
    n = 0;
    axi_wr(cacl_pkg::OFS_CTRL, {24'h00_0000, code}, cacl_pkg::RESP_OKAY);
    arm = zc_seen + 3;
    cq.push_back(exp_ticks * cacl_pkg::TICK_CYCLES);
    spin <= 1'b1;
    while (cq.size() > 0 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    spin <= 1'b0;
    chk("advance pending", 34'h0_0000_0000, 34'(cq.size()));
    repeat (4) @(posedge aclk);
    $display("test advance code %h done", code);
  endtask : adv_run

  // ****************************************************************
  // Clock, monitor and timeout
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Oldest expectation is taken off its queue as each result appears
  always @(posedge aclk) begin
    if (rvalid && rready && rq.size() > 0) chk("read", rq.pop_front(), {rresp, rdata});
    if (bvalid && bready && bq.size() > 0) chk("bresp", 34'(bq.pop_front()), 34'(bresp));
    since <= zero_cross ? 0 : since + 1;
    if (zero_cross) zc_seen <= zc_seen + 1;
    if (commutate && zc_seen == arm && cq.size() > 0) chk_time(cq.pop_front(), since);
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      final_report();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, lock_pin, oc_pin, spin} = '0;
    {awaddr, araddr, wdata, closed_loop} = '0;
    wstrb = 4'hF;
    motor = '0;
    gap = 8 * cacl_pkg::TICK_CYCLES;
    {errors, compares, arm, zc_seen, since, cycles} = '0;
    seed = 32'h2219_780f;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(cacl_pkg::OFS_CTRL, 32'h0000_0000, cacl_pkg::RESP_OKAY);
    axi_rd(cacl_pkg::OFS_MASK, 32'h0000_0000, cacl_pkg::RESP_OKAY);
    axi_rd(cacl_pkg::OFS_STATUS, 32'h0000_0000, cacl_pkg::RESP_OKAY);
    axi_rd(cacl_pkg::OFS_STATE, 32'h0000_0028, cacl_pkg::RESP_OKAY);
    axi_rd(4'h2, 32'h0000_0000, cacl_pkg::RESP_SLV);
    axi_wr(4'h2, 32'h0000_0001, cacl_pkg::RESP_SLV);
    axi_wr(cacl_pkg::OFS_CTRL, 32'hFFFF_FFFF, cacl_pkg::RESP_OKAY);
    axi_rd(cacl_pkg::OFS_CTRL, 32'h03FF_FFFF, cacl_pkg::RESP_OKAY);
    axi_wr(cacl_pkg::OFS_STATUS, 32'h0000_0003, cacl_pkg::RESP_OKAY);
    axi_rd(cacl_pkg::OFS_STATUS, 32'h0000_0000, cacl_pkg::RESP_OKAY);
    $display("test registers done");
    // Overcurrent with every setting at its top value
    oc_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("drive_enable", 34'h0, 34'(drive_enable));
    chk("lock_state", 34'h0, 34'(lock_state));
    oc_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("drive_enable", 34'h1, 34'(drive_enable));
    axi_rd(cacl_pkg::OFS_STATUS, 32'h0000_0002, cacl_pkg::RESP_OKAY);
    chk("irq", 34'h0, 34'(irq));
    $display("test overcurrent done");
    // Lock trip, unmasked
    axi_wr(cacl_pkg::OFS_MASK, 32'h0000_0001, cacl_pkg::RESP_OKAY);
    lock_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("lock_state", 34'h1, 34'(lock_state));
    chk("drive_enable", 34'h0, 34'(drive_enable));
    chk("irq", 34'h1, 34'(irq));
    lock_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("lock_state", 34'h1, 34'(lock_state));
    axi_rd(cacl_pkg::OFS_STATUS, 32'h0000_0001, cacl_pkg::RESP_OKAY);
    axi_rd(cacl_pkg::OFS_STATUS, 32'h0000_0000, cacl_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq", 34'h0, 34'(irq));
    axi_wr(cacl_pkg::OFS_STATE, 32'h0000_0001, cacl_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("lock_state", 34'h0, 34'(lock_state));
    chk("drive_enable", 34'h1, 34'(drive_enable));
    $display("test lock done");
    // Acceleration limit: threshold 2, resistance 10, constant 1, speed 30 gives 50
    axi_wr(cacl_pkg::OFS_CTRL, 32'h0008_A200, cacl_pkg::RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      u = (i == 0) ? 9'h020 : seed[8:0];
      cl = (i < 2) ? 1'b1 : seed[9];
      motor <= '{phase_amplitude: u, bemf_amplitude: 9'h000, speed: 10'h01e};
      closed_loop <= cl;
      repeat (3) @(posedge aclk);
      chk("drive_amplitude", 34'((cl && u > 50) ? 9'h032 : u), 34'(drive_amp));
      chk("accel_limit_active", 34'(cl && u > 50), 34'(accel_act));
      chk("drive_enable", 34'h1, 34'(drive_enable));
    end
    axi_rd(cacl_pkg::OFS_STATUS, 32'h0000_0000, cacl_pkg::RESP_OKAY);
    closed_loop <= 1'b0;
    motor <= '{phase_amplitude: 9'h0c8, bemf_amplitude: 9'h064, speed: 10'h000};
    $display("test acceleration limit done");
    // Advance: period 8 units, setting 6 units (code 13), scaled by half in mode one
    adv_run(8'h13, 2);
    adv_run(8'h93, 5);
    adv_run(8'h7F, 0);
    final_report();
  end
endmodule : tb_top
